// [core/spg_channel.sv]
`timescale 1ns/1ps
module spg_channel
	import spg_pkg::*;
#(
	parameter int FAST_DIV = FAST_DIV_DEF,
	parameter int UPD_DIV  = UPD_DIV_DEF,
	parameter int CAP_DIV  = CAP_DIV_DEF
) (
	input  wire logic               core_clk,
	input  wire logic               resetn,
	input  wire logic               enable,
	input  wire logic               ctrl_vel,
	input  wire logic [3:0]         step_type,
	input  wire logic signed [31:0] position_cmd,
	input  wire logic signed [31:0] velocity_cmd,
	input  wire logic [15:0]        position_scale,
	input  wire logic [31:0]        max_vel,
	input  wire logic [31:0]        max_accel,
	input  wire logic [31:0]        max_freq,
	input  wire logic [31:0]        step_len_ns,
	input  wire logic [31:0]        step_space_ns,
	input  wire logic [31:0]        dir_setup_ns,
	input  wire logic [31:0]        dir_hold_ns,
	input  wire logic [31:0]        dir_delay_ns,
	output logic                    step,
	output logic                    dir,
	output logic                    up,
	output logic                    down,
	output logic                    phase_a,
	output logic                    phase_b,
	output logic                    phase_c,
	output logic                    phase_d,
	output logic                    phase_e,
	output logic signed [31:0]      frequency,
	output logic signed [31:0]      raw_counts,
	output logic signed [31:0]      counts,
	output logic signed [31:0]      feedback_position
);

	localparam int TICK_NS = CLK_NS * FAST_DIV;
	localparam int FAST_HZ = CLK_HZ / FAST_DIV;
	localparam int UPD_HZ  = CLK_HZ / (FAST_DIV * UPD_DIV);
	localparam logic [63:0] KMUL = (64'h1 << 48) / 64'(FAST_HZ);

	// divider needs a full run between slow ticks
	if (FAST_DIV < 1 || UPD_DIV < 1 || CAP_DIV < 1 ||
		FAST_DIV * UPD_DIV < DIV_CYCLES ||
		FAST_DIV * CAP_DIV < DIV_CYCLES ||
		FAST_DIV > 65535 || UPD_DIV > 65535 || CAP_DIV > 65535) begin : g_bad
		$error("spg_channel: tick dividers out of range");
	end

	// ****************************************
	// helper functions
	// ****************************************
	function automatic logic [15:0] to_ticks(input logic [31:0] ns);
		logic [32:0] t;
		t = (33'(ns) + 33'(TICK_NS - 1)) / 33'(TICK_NS);
		to_ticks = (t > 33'h0_0000_FFFF) ? 16'hFFFF : t[15:0];
	endfunction : to_ticks

	function automatic logic [31:0] sat(input logic [47:0] x);
		sat = (x > 48'(RATE_MAX)) ? RATE_MAX : x[31:0];
	endfunction : sat

	function automatic logic [31:0] umin(input logic [31:0] a,
		input logic [31:0] b);
		umin = (a < b) ? a : b;
	endfunction : umin

	// {inverted, kind, phase count}; own table, patterns are arbitrary
	function automatic logic [5:0] ph_cfg(input logic [3:0] t);
		unique case (t)
			4'h2:    ph_cfg = {1'b0, SPG_QUAD,   3'd2};
			4'h3:    ph_cfg = {1'b0, SPG_FULL,   3'd3};
			4'h4:    ph_cfg = {1'b0, SPG_HALF,   3'd3};
			4'h5:    ph_cfg = {1'b0, SPG_FULL,   3'd4};
			4'h6:    ph_cfg = {1'b0, SPG_TWO_ON, 3'd4};
			4'h7:    ph_cfg = {1'b0, SPG_HALF,   3'd4};
			4'h8:    ph_cfg = {1'b1, SPG_FULL,   3'd4};
			4'h9:    ph_cfg = {1'b1, SPG_TWO_ON, 3'd4};
			4'hA:    ph_cfg = {1'b1, SPG_HALF,   3'd4};
			4'hB:    ph_cfg = {1'b0, SPG_FULL,   3'd5};
			4'hC:    ph_cfg = {1'b0, SPG_TWO_ON, 3'd5};
			4'hD:    ph_cfg = {1'b0, SPG_HALF,   3'd5};
			4'hE:    ph_cfg = {1'b1, SPG_HALF,   3'd5};
			default: ph_cfg = {1'b0, SPG_QUAD,   3'd0};
		endcase
	endfunction : ph_cfg

	function automatic logic [4:0] ph_pattern(input logic [5:0] cfg,
		input logic [3:0] s);
		logic [2:0] np;
		logic [2:0] k;
		logic [2:0] k1;
		np = cfg[2:0];
		k = (cfg[4:3] == SPG_HALF) ? s[3:1] : s[2:0];
		k1 = (k + 3'd1 == np) ? 3'd0 : k + 3'd1;
		ph_pattern = '0;
		for (int i = 0; i < 5; i++) begin
			if (3'(i) < np) begin
				ph_pattern[i] = (3'(i) == k) ||
					(cfg[4:3] == SPG_TWO_ON && 3'(i) == k1) ||
					(cfg[4:3] == SPG_HALF && s[0] && 3'(i) == k1);
				ph_pattern[i] = ph_pattern[i] ^ cfg[5];
			end
		end
		if (cfg[4:3] == SPG_QUAD) begin
			ph_pattern = {3'b000, s[1], s[1] ^ s[0]};
		end
	endfunction : ph_pattern

	// ****************************************
	// tick generation
	// ****************************************
	logic [15:0] fast_cnt_q;
	logic [15:0] upd_cnt_q;
	logic [15:0] cap_cnt_q;

	wire fast_tick = fast_cnt_q == 16'(FAST_DIV - 1);
	wire upd_tick  = fast_tick && upd_cnt_q == 16'(UPD_DIV - 1);
	wire cap_tick  = fast_tick && cap_cnt_q == 16'(CAP_DIV - 1);

	// common reset keeps every channel on the same tick phase
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fast_cnt_q <= '0;
			upd_cnt_q  <= '0;
			cap_cnt_q  <= '0;
		end else begin
			fast_cnt_q <= fast_tick ? '0 : fast_cnt_q + 16'h0001;
			if (fast_tick) begin
				upd_cnt_q <= upd_tick ? '0 : upd_cnt_q + 16'h0001;
				cap_cnt_q <= cap_tick ? '0 : cap_cnt_q + 16'h0001;
			end
		end
	end

	// ****************************************
	// timing settings in ticks
	// ****************************************
	logic [15:0] len_t_q;
	logic [15:0] space_t_q;
	logic [15:0] setup_t_q;
	logic [15:0] hold_t_q;
	logic [15:0] delay_t_q;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			len_t_q   <= TICKS_RST;
			space_t_q <= TICKS_RST;
			setup_t_q <= TICKS_RST;
			hold_t_q  <= TICKS_RST;
			delay_t_q <= TICKS_RST;
		end else if (upd_tick) begin
			len_t_q   <= to_ticks(step_len_ns);
			space_t_q <= to_ticks(step_space_ns);
			setup_t_q <= to_ticks(dir_setup_ns);
			hold_t_q  <= to_ticks(dir_hold_ns);
			delay_t_q <= to_ticks(dir_delay_ns);
		end
	end

	// ****************************************
	// step type decode
	// ****************************************
	wire is_sd = step_type == TYPE_STEP_DIR;
	wire is_ud = step_type == TYPE_UP_DOWN;
	wire is_ph = step_type >= TYPE_PHASE_MIN && step_type <= TYPE_PHASE_MAX;
	wire [5:0] cfg_w = ph_cfg(step_type);
	wire [3:0] nstates_w = (cfg_w[4:3] == SPG_QUAD) ? 4'd4 :
		(cfg_w[4:3] == SPG_HALF) ? {cfg_w[2:0], 1'b0} : {1'b0, cfg_w[2:0]};

	// ****************************************
	// rate limit from pulse timing
	// ****************************************
	wire [16:0] tsum_w = is_ph ? {1'b0, len_t_q} :
		17'(len_t_q) + 17'(space_t_q);
	wire [31:0] lim_den_w = 32'({15'h0000, tsum_w} * 32'(TICK_NS));
	wire        lim_busy;
	wire        lim_done;
	wire [31:0] lim_quot;
	logic [31:0] lim_q;

	spg_div #(.W(32)) u_lim_div (
		.core_clk (core_clk),
		.resetn   (resetn),
		.start    (upd_tick && lim_den_w != 32'h0000_0000),
		.num      (32'(NS_PER_S)),
		.den      (lim_den_w),
		.busy     (lim_busy),
		.done     (lim_done),
		.quot     (lim_quot)
	);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			lim_q <= RATE_MAX;
		end else if (lim_done) begin
			lim_q <= umin(lim_quot, RATE_MAX);
		end
	end

	// zero max_freq means no frequency cap, yet the timing limit still holds
	wire [31:0] fmax_w = (max_freq == 32'h0000_0000) ? lim_q :
		umin(max_freq, lim_q);
	wire [31:0] vmax_w = sat(max_vel * position_scale);
	wire [31:0] vlim_w = (vmax_w == 32'h0000_0000) ? fmax_w :
		umin(vmax_w, fmax_w);
	wire [31:0] acc_w  = sat(max_accel * position_scale);
	wire [31:0] dv_raw_w = acc_w / 32'(UPD_HZ);
	wire [31:0] dv_w = (dv_raw_w == 32'h0000_0000) ? 32'h0000_0001 : dv_raw_w;
	wire        unl_w = acc_w == 32'h0000_0000;

	// ****************************************
	// velocity and position loop, update tick
	// ****************************************
	logic signed [31:0] rate_q;
	logic signed [31:0] tgt_prev_q;
	logic [31:0]        incr_q;
	logic               sdir_q;

	wire signed [47:0] tgt_full_w = position_cmd * $signed({1'b0, position_scale});
	wire signed [47:0] vel_full_w = velocity_cmd * $signed({1'b0, position_scale});
	wire signed [31:0] tgt_w  = tgt_full_w[31:0];
	wire signed [47:0] vlim48 = $signed({16'h0000, vlim_w});
	wire signed [31:0] vlim_s = $signed(vlim_w);
	wire signed [31:0] vclamp_w = (vel_full_w > vlim48) ? vlim_s :
		(vel_full_w < -vlim48) ? -vlim_s : vel_full_w[31:0];

	wire signed [31:0] err_w  = tgt_w - raw_counts;
	wire signed [31:0] vcmd_w = 32'((tgt_w - tgt_prev_q) * UPD_HZ);
	wire signed [32:0] ve_w   = 33'(rate_q) - 33'(vcmd_w);
	wire [65:0] ve_sq_w = ve_w * ve_w;
	wire [31:0] aerr_w  = err_w[31] ? 32'(-err_w) : 32'(err_w);
	wire [65:0] brake_w = {acc_w, 1'b0} * aerr_w;
	wire short_w = ve_sq_w < brake_w;
	wire err_pos = !err_w[31] && err_w != 32'sh0000_0000;
	wire go_up_w = err_pos ? (ve_w < 0 || short_w) : !(ve_w > 0 || short_w);

	wire signed [31:0] goal_pos_w = unl_w ?
		32'(err_w * UPD_HZ) + vcmd_w :
		(err_w == 32'sh0000_0000) ? vcmd_w :
		go_up_w ? vlim_s : -vlim_s;
	wire signed [31:0] goal_w = ctrl_vel ? vclamp_w : goal_pos_w;

	wire signed [33:0] gap_w  = 34'(goal_w) - 34'(rate_q);
	wire signed [33:0] dv_s   = $signed({2'b00, dv_w});
	wire signed [33:0] ramp_w = unl_w ? 34'(goal_w) :
		(gap_w > dv_s) ? 34'(rate_q) + dv_s :
		(gap_w < -dv_s) ? 34'(rate_q) - dv_s : 34'(goal_w);
	wire signed [33:0] vl34 = $signed({2'b00, vlim_w});
	wire signed [31:0] vnext_w = (ramp_w > vl34) ? vlim_s :
		(ramp_w < -vl34) ? -vlim_s : ramp_w[31:0];

	wire [31:0] vmag_w = vnext_w[31] ? 32'(-vnext_w) : 32'(vnext_w);
	wire [63:0] prod_w = 64'(vmag_w) * KMUL;
	wire [31:0] incr_w = (prod_w[63:48] != 16'h0000) ? 32'hFFFF_FFFF :
		prod_w[47:16];

	// all scaling and limiting stay off the fast tick
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rate_q     <= '0;
			tgt_prev_q <= '0;
			incr_q     <= '0;
			sdir_q     <= 1'b0;
		end else if (upd_tick) begin
			tgt_prev_q <= tgt_w;
			rate_q     <= enable ? vnext_w : '0;
			incr_q     <= enable ? incr_w : '0;
			sdir_q     <= vnext_w[31];
		end
	end

	// ****************************************
	// step timing engine, fast tick
	// ****************************************
	logic [31:0] acc_q;
	logic        pend_q;
	logic        pend_dir_q;
	logic        dir_q;
	logic        last_dir_q;
	logic [15:0] hi_q;
	logic [15:0] sp_q;
	logic [15:0] hd_q;
	logic [15:0] su_q;
	logic [15:0] rv_q;
	logic [3:0]  pstate_q;

	wire [32:0] acc_sum_w = 33'(acc_q) + 33'(incr_q);
	wire carry_w = fast_tick && enable && acc_sum_w[32];
	wire idle_w  = hi_q == 16'h0000 && sp_q == 16'h0000;
	wire same_w  = pend_dir_q == last_dir_q;
	wire start_w = fast_tick && enable && pend_q && idle_w &&
		(is_sd ? (pend_dir_q == dir_q && su_q == 16'h0000) :
		(same_w || rv_q == 16'h0000));
	wire dchg_w  = fast_tick && is_sd && pend_q && pend_dir_q != dir_q &&
		hi_q == 16'h0000 && hd_q == 16'h0000;
	wire hi_end_w = fast_tick && hi_q == 16'h0001;
	wire [15:0] hi_load_w = (len_t_q == 16'h0000) ? 16'h0001 : len_t_q;
	wire [3:0]  ps_up_w = (pstate_q + 4'd1 >= nstates_w) ? 4'd0 : pstate_q + 4'd1;
	wire [3:0]  ps_dn_w = (pstate_q == 4'd0) ? nstates_w - 4'd1 : pstate_q - 4'd1;

	function automatic logic [15:0] dec(input logic [15:0] c);
		dec = (c == 16'h0000) ? c : c - 16'h0001;
	endfunction : dec

	// one pending step only; the rate limit keeps carries further apart
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_q      <= '0;
			pend_q     <= 1'b0;
			pend_dir_q <= 1'b0;
		end else if (fast_tick) begin
			acc_q  <= enable ? acc_sum_w[31:0] : '0;
			pend_q <= carry_w || (pend_q && !start_w && enable);
			if (carry_w) begin
				pend_dir_q <= sdir_q;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hi_q <= '0;
			sp_q <= '0;
			hd_q <= '0;
			su_q <= '0;
			rv_q <= '0;
		end else if (fast_tick) begin
			hi_q <= start_w ? hi_load_w : dec(hi_q);
			sp_q <= (hi_end_w && !is_ph) ? space_t_q : dec(sp_q);
			hd_q <= (hi_end_w && is_sd) ? hold_t_q : dec(hd_q);
			su_q <= dchg_w ? setup_t_q : dec(su_q);
			rv_q <= start_w ? delay_t_q : dec(rv_q);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			dir_q      <= 1'b0;
			last_dir_q <= 1'b0;
			pstate_q   <= '0;
			raw_counts <= '0;
		end else begin
			if (dchg_w) begin
				dir_q <= pend_dir_q;
			end
			if (start_w) begin
				last_dir_q <= pend_dir_q;
				pstate_q   <= pend_dir_q ? ps_dn_w : ps_up_w;
				raw_counts <= pend_dir_q ? raw_counts - 32'sh0000_0001 :
					raw_counts + 32'sh0000_0001;
			end else if (pstate_q >= nstates_w) begin
				pstate_q <= '0;
			end
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	// a started pulse runs out, so every counted step reaches the pin, except under step type 15, which drives no pin
	wire        pulse_w = hi_q != 16'h0000;
	wire [4:0]  ph_w    = is_ph ? ph_pattern(cfg_w, pstate_q) : 5'h00;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			step      <= 1'b0;
			dir       <= 1'b0;
			up        <= 1'b0;
			down      <= 1'b0;
			{phase_e, phase_d, phase_c, phase_b, phase_a} <= 5'h00;
			frequency <= '0;
		end else begin
			step <= is_sd && pulse_w;
			dir  <= is_sd && dir_q;
			up   <= is_ud && pulse_w && !last_dir_q;
			down <= is_ud && pulse_w && last_dir_q;
			{phase_e, phase_d, phase_c, phase_b, phase_a} <= ph_w;
			frequency <= rate_q;
		end
	end

	// ****************************************
	// feedback capture
	// ****************************************
	logic        fb_neg_q;
	wire         fb_busy;
	wire         fb_done;
	wire [31:0]  fb_quot;
	wire [31:0]  raw_mag_w = raw_counts[31] ? 32'(-raw_counts) : 32'(raw_counts);

	// counts beyond 2^24 wrap in the fixed point feedback value
	spg_div #(.W(32)) u_fb_div (
		.core_clk (core_clk),
		.resetn   (resetn),
		.start    (cap_tick),
		.num      ({raw_mag_w[31-FB_FRAC:0], FB_FRAC'(0)}),
		.den      ({16'h0000, position_scale}),
		.busy     (fb_busy),
		.done     (fb_done),
		.quot     (fb_quot)
	);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			counts            <= '0;
			fb_neg_q          <= 1'b0;
			feedback_position <= '0;
		end else begin
			if (cap_tick) begin
				counts   <= raw_counts;
				fb_neg_q <= raw_counts[31];
			end
			if (fb_done) begin
				feedback_position <= (position_scale == 16'h0000) ? '0 :
					fb_neg_q ? -$signed(fb_quot) : $signed(fb_quot);
			end
		end
	end

endmodule : spg_channel

// [core/spg_pkg.sv]
package spg_pkg;

	// ****************************************
	// clock and tick rates
	// ****************************************
	localparam int CLK_HZ       = 10_000_000;
	localparam int CLK_NS       = 100;
	localparam int NS_PER_S     = 1_000_000_000;
	localparam int FAST_DIV_DEF = 10;
	localparam int UPD_DIV_DEF  = 100;
	localparam int CAP_DIV_DEF  = 100;
	localparam int DIV_CYCLES   = 34;

	// ****************************************
	// reset values and formats
	// ****************************************
	localparam int          DEF_TIME_NS = 1;
	localparam logic [15:0] TICKS_RST   = 16'h0001;
	localparam int          FB_FRAC     = 8;
	localparam logic [31:0] RATE_MAX    = 32'h7FFF_FFFF;

	// ****************************************
	// step types
	// ****************************************
	localparam logic [3:0] TYPE_STEP_DIR  = 4'h0;
	localparam logic [3:0] TYPE_UP_DOWN   = 4'h1;
	localparam logic [3:0] TYPE_PHASE_MIN = 4'h2;
	localparam logic [3:0] TYPE_PHASE_MAX = 4'hE;

	typedef enum logic [1:0] {
		SPG_FULL,
		SPG_TWO_ON,
		SPG_HALF,
		SPG_QUAD
	} spg_kind_t;

endpackage : spg_pkg

// [core/spg_div.sv]
`timescale 1ns/1ps
module spg_div
	import spg_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      quot
);

	localparam int CW = $clog2(W + 1);

	if (W < 2) begin : g_bad_width
		$error("spg_div: width too small");
	end

	logic [W:0]   rem_q;
	logic [W-1:0] den_q;
	logic [CW-1:0] cnt_q;

	// ****************************************
	// restoring long division, one bit a cycle
	// ****************************************
	wire [W:0] trial_w = {rem_q[W-1:0], quot[W-1]} - {1'b0, den_q};
	wire       fits_w  = !trial_w[W];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			quot  <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else if (!busy) begin
			done <= 1'b0;
			if (start) begin
				rem_q <= '0;
				quot  <= num;
				den_q <= den;
				cnt_q <= CW'(W);
				busy  <= 1'b1;
			end
		end else begin
			rem_q <= fits_w ? trial_w : {rem_q[W-1:0], quot[W-1]};
			quot  <= {quot[W-2:0], fits_w};
			cnt_q <= cnt_q - 1'b1;
			busy  <= cnt_q != CW'(1);
			done  <= cnt_q == CW'(1);
		end
	end

endmodule : spg_div

// [verification/spg_channel_monitor.sv]
`timescale 1ns/1ps
module spg_channel_monitor
	import spg_pkg::*;
#(
	parameter int FAST_DIV = FAST_DIV_DEF,
	parameter int UPD_DIV  = UPD_DIV_DEF,
	parameter int CAP_DIV  = CAP_DIV_DEF
) (
	input wire logic               core_clk,
	input wire logic               resetn,
	input wire logic               enable,
	input wire logic [3:0]         step_type,
	input wire logic [31:0]        step_len_ns,
	input wire logic [31:0]        step_space_ns,
	input wire logic [31:0]        dir_setup_ns,
	input wire logic [31:0]        dir_hold_ns,
	input wire logic               step,
	input wire logic               dir,
	input wire logic               up,
	input wire logic               down,
	input wire logic               phase_a,
	input wire logic               phase_b,
	input wire logic               phase_c,
	input wire logic               phase_d,
	input wire logic               phase_e,
	input wire logic signed [31:0] frequency,
	input wire logic signed [31:0] raw_counts,
	input wire logic signed [31:0] counts
);
	// ********************
	// tick figures
	// ********************
	localparam int TNS  = FAST_DIV * CLK_NS;
	localparam int SETL = 3 * FAST_DIV * UPD_DIV;
	logic [31:0] len_t, spc_t, len_c, spc_c, set_c, hld_c, lim, mag;
	logic        pulse, dir_q, gate_ok, in_rng;
	logic [3:0]  type_q;
	logic [15:0] hi_n, lo_n, dir_n, stab_n, off_n;

	function automatic logic [15:0] sat(input logic [15:0] v);
		return v + {15'h0000, v != 16'hFFFF};
	endfunction : sat

	// partial ticks round up, so these are ceilings
	assign len_t = (step_len_ns + 32'(TNS - 1)) / 32'(TNS);
	assign spc_t = (step_space_ns + 32'(TNS - 1)) / 32'(TNS);
	assign len_c = len_t * 32'(FAST_DIV);
	assign spc_c = spc_t * 32'(FAST_DIV);
	assign set_c = (dir_setup_ns + 32'(TNS - 1)) / 32'(TNS) * 32'(FAST_DIV);
	assign hld_c = (dir_hold_ns + 32'(TNS - 1)) / 32'(TNS) * 32'(FAST_DIV);
	assign lim   = (step_type < TYPE_PHASE_MIN)
		? 32'(NS_PER_S) / ((len_t + spc_t) * 32'(TNS))
		: 32'(NS_PER_S) / (len_t * 32'(TNS));
	assign mag     = frequency[31] ? 32'(-frequency) : 32'(frequency);
	assign pulse   = step | up | down;
	assign in_rng  = step_type >= TYPE_PHASE_MIN && step_type <= TYPE_PHASE_MAX;
	assign gate_ok = (in_rng || !phase_a && !phase_b)
		&& (in_rng && step_type >= 4'h3 || !phase_c)
		&& (in_rng && step_type >= 4'h5 || !phase_d)
		&& (in_rng && step_type >= 4'hB || !phase_e);

	// counters saturate, so an idle line never wraps into a false failure
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hi_n   <= 16'h0000;
			lo_n   <= 16'hFFFF;
			dir_n  <= 16'hFFFF;
			stab_n <= 16'h0000;
			off_n  <= 16'h0000;
			dir_q  <= 1'b0;
			type_q <= 4'h0;
		end else begin
			hi_n   <= pulse ? sat(hi_n) : 16'h0000;
			lo_n   <= pulse ? 16'h0000 : sat(lo_n);
			dir_n  <= (dir != dir_q) ? 16'h0001 : sat(dir_n);
			stab_n <= (step_type != type_q) ? 16'h0000 : sat(stab_n);
			off_n  <= enable ? 16'h0000 : sat(off_n);
			dir_q  <= dir;
			type_q <= step_type;
		end
	end

	// ********************
	// properties
	// ********************
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence off_s;
		(!enable) [*4];
	endsequence
	sequence held_s;
		$stable(step_type) [*3];
	endsequence

	pulse_len_a: assert property ($fell(pulse) |-> hi_n == len_c[15:0])
		else $error("pulse width differs from rounded length");
	pulse_space_a: assert property ($rose(pulse) |-> lo_n >= spc_c[15:0])
		else $error("pulse spacing too short");
	dir_setup_a: assert property ($rose(step) && step_type == TYPE_STEP_DIR
		|-> dir_n >= set_c[15:0]) else $error("step too soon after dir change");
	dir_hold_a: assert property ($changed(dir) && step_type == TYPE_STEP_DIR
		|-> !step && lo_n >= hld_c[15:0]) else $error("dir changed too early");
	quiet_off_a: assert property (off_s |-> !$rose(step) && !$rose(up)
		&& !$rose(down)) else $error("step while disabled");
	idle_rate_a: assert property (off_n >= SETL |-> frequency == 0)
		else $error("rate not zero while disabled");
	phase_gate_a: assert property (held_s |-> gate_ok)
		else $error("phase output active for wrong type");
	out_select_a: assert property (held_s |-> (step_type == TYPE_STEP_DIR
		|| !step) && (step_type == TYPE_UP_DOWN || !up && !down))
		else $error("pulse on output of another type");
	updown_excl_a: assert property ($rose(up) |-> !down)
		else $error("up and down together");
	count_latch_a: assert property ($changed(counts)
		|-> counts == $past(raw_counts)) else $error("latched count wrong");
	rate_cap_a: assert property (stab_n >= SETL |-> mag <= lim)
		else $error("rate above timing limit");
endmodule : spg_channel_monitor

bind spg_channel spg_channel_monitor #(.FAST_DIV(FAST_DIV),
	.UPD_DIV(UPD_DIV), .CAP_DIV(CAP_DIV)) mon_u (.core_clk, .resetn,
	.enable, .step_type, .step_len_ns, .step_space_ns, .dir_setup_ns,
	.dir_hold_ns, .step, .dir, .up, .down, .phase_a, .phase_b, .phase_c,
	.phase_d, .phase_e, .frequency, .raw_counts, .counts);

// [verification/spg_motor_model.sv]
`timescale 1ns/1ps
module spg_motor_model
	import spg_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          resetn,
	input  wire logic [3:0]    step_type,
	input  wire logic          step,
	input  wire logic          dir,
	input  wire logic          up,
	input  wire logic          down,
	input  wire logic          phase_a,
	input  wire logic          phase_b,
	output logic signed [31:0] pos
);
	// ********************
	// shaft position
	// ********************
	logic       step_q, up_q, down_q;
	logic [1:0] idx, idx_q;

	// gray order 00,01,11,10 read as 0..3; other phase types not tracked
	assign idx = {phase_b, phase_b ^ phase_a};

	always @(posedge core_clk) begin
		if (!resetn) begin
			pos    <= 32'sh0;
			step_q <= 1'b0;
			up_q   <= 1'b0;
			down_q <= 1'b0;
			idx_q  <= 2'h0;
		end else begin
			step_q <= step;
			up_q   <= up;
			down_q <= down;
			idx_q  <= idx;
			if (step && !step_q && step_type == TYPE_STEP_DIR)
				pos <= dir ? pos - 32'sh1 : pos + 32'sh1;
			else if (up && !up_q)
				pos <= pos + 32'sh1;
			else if (down && !down_q)
				pos <= pos - 32'sh1;
			else if (step_type == TYPE_PHASE_MIN && idx == idx_q + 2'h1)
				pos <= pos + 32'sh1;
			else if (step_type == TYPE_PHASE_MIN && idx == idx_q - 2'h1)
				pos <= pos - 32'sh1;
		end
	end
endmodule : spg_motor_model

// [verification/spg_channel_tb.sv]
`timescale 1ns/1ps
module spg_channel_tb
	import spg_pkg::*;
;
	// ********************
	// bench set-up
	// ********************
	localparam int FD    = 2;
	localparam int UD    = 20;
	localparam int LIMIT = 90000;
	logic               core_clk, resetn, enable, ctrl_vel;
	logic               step, dir, up, down;
	logic               phase_a, phase_b, phase_c, phase_d, phase_e;
	logic [3:0]         step_type;
	logic [15:0]        position_scale;
	logic [31:0]        max_vel, max_accel, max_freq;
	logic [31:0]        step_len_ns, step_space_ns;
	logic [31:0]        dir_setup_ns, dir_hold_ns, dir_delay_ns;
	logic signed [31:0] position_cmd, velocity_cmd, frequency;
	logic signed [31:0] raw_counts, counts, feedback_position;
	logic signed [31:0] pos, r0, peak, mag;
	int                 err_total, n_tests, cyc;

	spg_channel #(.FAST_DIV(FD), .UPD_DIV(UD), .CAP_DIV(UD)) dut_u (
		.core_clk, .resetn, .enable, .ctrl_vel, .step_type, .position_cmd,
		.velocity_cmd, .position_scale, .max_vel, .max_accel, .max_freq,
		.step_len_ns, .step_space_ns, .dir_setup_ns, .dir_hold_ns,
		.dir_delay_ns, .step, .dir, .up, .down, .phase_a, .phase_b,
		.phase_c, .phase_d, .phase_e, .frequency, .raw_counts, .counts,
		.feedback_position);
	spg_motor_model drv_u (.core_clk, .resetn, .step_type, .step, .dir,
		.up, .down, .phase_a, .phase_b, .pos);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_total++;
			summarize();
		end
	end

	// ********************
	// tasks
	// ********************
	task automatic summarize;
		if (err_total == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		n_tests++;
		if (act !== exp) begin
			err_total++;
			$display("wrong value at %0t: %0d not %0d", $time, act, exp);
		end
	endtask : chk
	task automatic chk_rng(input logic signed [31:0] act, lo, hi);
		n_tests++;
		if ((act >= lo && act <= hi) !== 1'b1) begin
			err_total++;
			$display("wrong value at %0t: %0d out of range", $time, act);
		end
	endtask : chk_rng
	task automatic run(input int n);
		repeat (n) @(negedge core_clk);
	endtask : run
	task automatic rst;
		resetn = 1'b0;
		run(4);
		resetn = 1'b1;
		run(2);
	endtask : rst

	// ********************
	// sequence
	// ********************
	initial begin
		err_total = 0; n_tests = 0; cyc = 0;
		enable = 1'b1; ctrl_vel = 1'b1; step_type = TYPE_STEP_DIR;
		position_cmd = 32'sh0; velocity_cmd = 32'sh0;
		position_scale = 16'h000A; max_freq = 32'h0;
		max_vel = 32'h0; max_accel = 32'h0;
		step_len_ns = 32'h1F4; // three ticks
		step_space_ns = 32'hC9; // just over one tick, so two
		dir_setup_ns = 32'h190; dir_hold_ns = 32'h258; dir_delay_ns = 32'h3E8;
		rst();
		chk(raw_counts, 32'h0);
		chk({28'h0, step, dir, up, down}, 32'h0);
		velocity_cmd = 32'sh1388;
		run(400);
		chk(frequency, 32'hC350);
		run(2000);
		chk_rng(raw_counts, 32'sh8, 32'shD);
		velocity_cmd = -32'sh1388;
		run(3000);
		velocity_cmd = 32'sh0;
		run(400);
		chk_rng(raw_counts, -32'sh9, -32'sh1);
		chk(pos, raw_counts);
		chk(counts, raw_counts);
		mag = raw_counts < 0 ? -raw_counts : raw_counts;
		mag = mag * 32'sh100 / 32'(position_scale);
		chk(feedback_position, raw_counts < 0 ? -mag : mag);
		max_vel = 32'h7D0; velocity_cmd = 32'sh1388; max_freq = 32'hF4240;
		run(400);
		chk(frequency, 32'h4E20);
		max_vel = 32'h0; velocity_cmd = 32'sh0;
		run(400);
		max_accel = 32'h98_9680; velocity_cmd = 32'sh1388;
		run(120);
		chk_rng(frequency, 32'sh1, 32'shC34F);
		run(6000);
		chk(frequency, 32'hC350);
		max_accel = 32'h0; enable = 1'b0;
		run(300);
		r0 = raw_counts;
		run(300);
		chk(raw_counts, r0);
		chk(frequency, 32'h0);
		enable = 1'b1; velocity_cmd = 32'sh0; dir_delay_ns = 32'h7D0;
		run(200);
		step_type = TYPE_UP_DOWN; velocity_cmd = -32'sh1388; r0 = raw_counts;
		run(2000);
		chk_rng(raw_counts - r0, -32'shD, -32'sh8);
		velocity_cmd = 32'sh1388;
		run(2000);
		velocity_cmd = 32'sh0;
		run(400);
		chk(pos, raw_counts);
		step_type = TYPE_PHASE_MIN;
		rst();
		velocity_cmd = 32'sh1388;
		run(2000);
		velocity_cmd = 32'sh0;
		run(400);
		chk_rng(raw_counts, 32'sh8, 32'shD);
		chk(pos, raw_counts);
		for (int t = 3; t <= 15; t++) begin
			step_type = 4'(t); velocity_cmd = 32'sh1388; r0 = raw_counts;
			run(800);
			velocity_cmd = 32'sh0;
			run(300);
			if (t < 15) chk_rng(raw_counts - r0, 32'sh2, 32'sh6);
		end
		step_type = TYPE_STEP_DIR; ctrl_vel = 1'b0; position_scale = 16'h0005;
		rst();
		position_cmd = 32'sh6; max_vel = 32'h7D0; max_accel = 32'h5F5_E100;
		peak = 32'sh0;
		for (int i = 0; i < 40000 && raw_counts !== 32'sh1E; i++) begin
			run(1);
			if ((frequency < 0 ? -frequency : frequency) > peak) peak = frequency;
		end
		chk(raw_counts, 32'h1E);
		chk_rng(peak, 32'sh1, 32'sh2710);
		enable = 1'b0;
		run(300);
		chk(pos, raw_counts);
		chk_rng(raw_counts, 32'sh1D, 32'sh1F);
		summarize();
	end
endmodule : spg_channel_tb
